// >>> dv/rtt_top_sva.sv
// Port assertions for the RTC block
`timescale 1ns/1ps
module rtt_top_sva (
  // Clock and reset
  input wire ref_clk,
  input wire sys_rst,
  input wire clk_en,
  // Bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata,
  // Slow clocks and outputs
  input wire int_slow_clk,
  input wire ext_slow_clk,
  input wire internal_slow_osc_power,
  input wire external_slow_osc_power,
  input wire slow_clock_source_select,
  input wire match_event_flag,
  input wire period_event_flag
);
  reg ap_r;
  reg aw_r;
  reg [7:0] aa_r;
  wire rd_ok = ap_r && !aw_r && hready;
  wire wr_ok = ap_r && aw_r && hready;
  wire [2:0] cfg = {slow_clock_source_select, internal_slow_osc_power,
    external_slow_osc_power};
  // Tracks the pending data phase
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      ap_r <= 1'b0;
      aw_r <= 1'b0;
      aa_r <= 8'h00;
    end else if (hready) begin
      ap_r <= hsel && htrans[1] && clk_en;
      aw_r <= hwrite;
      aa_r <= haddr[7:0];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_reset_state: assert property ($past(sys_rst) |-> cfg == 3'h2
    && !match_event_flag && !period_event_flag) else $error("reset state");
  a_cfg_write: assert property (wr_ok && aa_r == 8'h00
    |=> cfg == $past(hwdata[2:0])) else $error("config write");
  a_cfg_read: assert property (rd_ok && aa_r == 8'h00
    |-> hrdata[6:0] == {4'h0, $past(cfg)}) else $error("config read");
  a_day_upper: assert property (rd_ok && aa_r == 8'h20
    |-> hrdata[31:14] == 18'h0) else $error("day upper bits");
  a_match_on_tick: assert property ($rose(match_event_flag)
    |-> $past(int_slow_clk, 3) || $past(ext_slow_clk, 3)) else $error("match");
  a_period_on_tick: assert property ($rose(period_event_flag)
    |-> $past(int_slow_clk, 3) || $past(ext_slow_clk, 3)) else $error("period");
  a_match_clear: assert property ($fell(match_event_flag)
    |-> $past(wr_ok && aa_r == 8'h0C && hwdata[5])) else $error("match clr");
  a_period_clear: assert property ($fell(period_event_flag)
    |-> $past(wr_ok && aa_r == 8'h0C && hwdata[4])) else $error("period clr");
  c_match: cover property ($rose(match_event_flag));
  c_period: cover property ($rose(period_event_flag));
  c_cfg_wr: cover property (wr_ok && aa_r == 8'h00);
endmodule
bind rtt_top rtt_top_sva u_rtt_top_sva (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .int_slow_clk(int_slow_clk), .ext_slow_clk(ext_slow_clk),
  .internal_slow_osc_power(internal_slow_osc_power),
  .external_slow_osc_power(external_slow_osc_power),
  .slow_clock_source_select(slow_clock_source_select),
  .match_event_flag(match_event_flag), .period_event_flag(period_event_flag));

// >>> dv/rtt_top_tb_top.sv
// Register-level bench for the RTC block
`timescale 1ns/1ps
module rtt_top_tb_top;
  reg ref_clk = 1'b0;
  reg sys_rst = 1'b1;
  reg hsel = 1'b0;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h0;
  reg slow_i = 1'b0;
  reg slow_x = 1'b0;
  reg clk_en = 1'b1;
  wire hreadyout, hresp, ip, ep, ss, mf, pf;
  wire [31:0] hrdata;
  integer n_errors = 0;
  integer checks = 0;
  integer cyc = 0;
  integer c;
  reg [31:0] q;
  reg [31:0] p;
  rtt_top u_rtt_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .int_slow_clk(slow_i), .ext_slow_clk(slow_x),
    .internal_slow_osc_power(ip), .external_slow_osc_power(ep),
    .slow_clock_source_select(ss), .match_event_flag(mf),
    .period_event_flag(pf));
  initial forever #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      test_done;
    end
  end
  task test_done;
    $display("checks=%0d errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task cmp(input [31:0] g, input [31:0] e);
    checks = checks + 1;
    if (g !== e) begin
      n_errors = n_errors + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One single AHB-Lite transfer, address phase then data phase
  task ahb(input w, input [7:0] a, input [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    q = hrdata;
    @(posedge ref_clk);
  endtask
  task wr(input [7:0] a, input [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task chk(input [7:0] a, input [31:0] e);
    ahb(1'b0, a, 32'h0);
    cmp(q, e);
  endtask
  // Slow clock periods of 8 cycles on one source, then settle
  task tick(input integer n, input x);
    repeat (n) begin
      if (x) slow_x <= 1'b1;
      else slow_i <= 1'b1;
      repeat (4) @(posedge ref_clk);
      slow_x <= 1'b0;
      slow_i <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
    repeat (4) @(posedge ref_clk);
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    chk(8'h00, 32'h02);
    cmp({hresp, ss, ip, ep}, 32'h2);
    chk(8'h08, 32'h02);
    chk(8'h0C, 32'h30);
    chk(8'h10, 32'h02);
    chk(8'h14, 32'h0);
    chk(8'h24, 32'h0);
    wr(8'h14, 32'hFFFFFFFF);
    wr(8'h10, 32'h80);
    chk(8'h20, 32'h3FFF);
    wr(8'h14, 32'hA8BF0000);
    wr(8'h10, 32'h80);
    chk(8'h20, 32'h0);
    wr(8'h14, 32'hA8BFFFFF);
    wr(8'h10, 32'h40);
    chk(8'h18, 32'hFFFF);
    chk(8'h1C, 32'hA8BF);
    chk(8'h10, 32'h0);
    tick(1, 1'b0);
    chk(8'h18, 32'h0);
    chk(8'h1C, 32'h0);
    chk(8'h20, 32'h1);
    wr(8'h00, 32'h5);
    cmp({ss, ip, ep}, 32'h5);
    tick(1, 1'b0);
    chk(8'h18, 32'h0);
    tick(1, 1'b1);
    chk(8'h18, 32'h1);
    wr(8'h00, 32'h2);
    wr(8'h14, 32'h0);
    wr(8'h10, 32'h40);
    wr(8'h14, 32'h5);
    wr(8'h10, 32'h28);
    chk(8'h0C, 32'h10);
    tick(3, 1'b0);
    cmp(mf, 32'h0);
    tick(1, 1'b0);
    cmp(mf, 32'h1);
    chk(8'h0C, 32'h90);
    wr(8'h10, 32'h0);
    wr(8'h0C, 32'h20);
    cmp(mf, 32'h1);
    wr(8'h10, 32'h20);
    wr(8'h0C, 32'h20);
    cmp(mf, 32'h0);
    chk(8'h0C, 32'h10);
    for (c = 0; c < 8; c = c + 1) begin
      p = 32'h1000 << c;
      wr(8'h14, 3 * p - p / 2 - 1);
      wr(8'h10, 32'h50 | c);
      tick(1, 1'b0);
      cmp(pf, 32'h0);
      wr(8'h14, 3 * p - 1);
      wr(8'h10, 32'h50 | c);
      tick(1, 1'b0);
      cmp(pf, 32'h1);
      chk(8'h0C, 32'h60);
      wr(8'h0C, 32'h10);
      cmp(pf, 32'h0);
    end
    wr(8'h10, 32'h0);
    wr(8'h08, 32'h1);
    chk(8'h08, 32'h3);
    tick(6, 1'b0);
    chk(8'h04, 32'h28);
    chk(8'h08, 32'h1);
    wr(8'h08, 32'h0);
    chk(8'h08, 32'h2);
    tick(6, 1'b0);
    chk(8'h04, 32'h28);
    slow_i <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk(8'h00, 32'h82);
    slow_i <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk(8'h00, 32'h02);
    // Frozen by the clock enable: no tick, bus stalled
    wr(8'h14, 32'h0);
    wr(8'h10, 32'h40);
    clk_en <= 1'b0;
    tick(1, 1'b0);
    cmp({hreadyout, ss, ip, ep}, 32'h2);
    clk_en <= 1'b1;
    chk(8'h18, 32'h0);
    test_done;
  end
endmodule

// >>> rtl/rtt_consts.vh
// Register map, field positions, reset values and counts for the RTC block
`ifndef RTT_CONSTS_VH
`define RTT_CONSTS_VH

// Register byte offsets, one aligned word each
`define RTT_OFS_OSC_CFG 8'h00
`define RTT_OFS_CAL_CNT 8'h04
`define RTT_OFS_CAL_CTL 8'h08
`define RTT_OFS_FLAGS 8'h0C
`define RTT_OFS_MODE 8'h10
`define RTT_OFS_MATCH 8'h14
`define RTT_OFS_SUB_SEC 8'h18
`define RTT_OFS_TWO_SEC 8'h1C
`define RTT_OFS_DAY 8'h20

// Oscillator configuration fields
`define RTT_CFG_PIN 7
`define RTT_CFG_SRC 2
`define RTT_CFG_INT_PON 1
`define RTT_CFG_EXT_PON 0
`define RTT_RST_SRC 1'b0
`define RTT_RST_INT_PON 1'b1
`define RTT_RST_EXT_PON 1'b0

// Calibration control fields
`define RTT_CAL_PAUSED 1
`define RTT_CAL_EN 0
`define RTT_CAL_W 12
`define RTT_CAL_PERIODS 3'h5
`define RTT_CAL_MAX 12'hFFF

// Flag register fields
`define RTT_FLG_MATCH 7
`define RTT_FLG_PERIOD 6
`define RTT_FLG_MATCH_CLR 5
`define RTT_FLG_PERIOD_CLR 4

// Mode register fields
`define RTT_MOD_LOAD_DAY 7
`define RTT_MOD_LOAD_SEC 6
`define RTT_MOD_MATCH_EN 5
`define RTT_MOD_PERIOD_EN 4
`define RTT_MOD_SKIP_LSB 3
`define RTT_MOD_PSEL_HI 2
`define RTT_MOD_PSEL_LO 0
`define RTT_RST_PSEL 3'h2

// Counter widths and wrap points
`define RTT_DAY_W 14
`define RTT_SUB_LAST 16'hFFFF
`define RTT_TWO_SEC_LAST 16'hA8BF
`define RTT_PER_BASE 32'h00001000
`define RTT_SKIP_MASK 32'hFFFFFFFE

`endif

// >>> rtl/rtt_sync.v
// Two-stage synchroniser for asynchronous levels
`timescale 1ns/1ps
module rtt_sync #(
  parameter W = 1
) (
  // Clock and control
  input wire ref_clk,
  input wire sys_rst,
  input wire clk_en,
  // Levels
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);

  reg [W-1:0] meta_r;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      meta_r <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else if (clk_en) begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// >>> rtl/rtt_top.v
// RTC with slow-clock control, calibration counter and AHB-Lite registers
// What this block does
// - Source select bit picks external or internal
// - Bit one powers internal slow oscillator
// - Bit zero powers external slow oscillator
// - Bit seven shows slow clock level
// - Count main cycles over five slow periods
// - Calibration runs only while enable set
// - Paused bit high unless count running
// - Match flag set on trigger event
// - Period flag set when interval elapses
// - Match clear reads one when disabled
// - Period clear reads one when disabled
// - Load bit copies 14 bits to days
// - Load bit presets both second counters
// - Mode bit five enables match trigger
// - Mode bit four enables period timing
// - Skip bit ignores match value LSB
// - Period code selects 0.125 to 16 s
// - Match both halves sets match flag
// - Each elapsed interval sets period flag
// - Day count in low 14 bits
`timescale 1ns/1ps
`include "rtt_consts.vh"
module rtt_top (
  // Clock, reset, enable
  input wire ref_clk,
  input wire sys_rst,
  input wire clk_en,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // Slow oscillators
  input wire int_slow_clk,
  input wire ext_slow_clk,
  output wire internal_slow_osc_power,
  output wire external_slow_osc_power,
  output wire slow_clock_source_select,
  // Event flags
  output wire match_event_flag,
  output wire period_event_flag
);

  // Configuration and mode state
  reg src_sel_r;
  reg int_pon_r;
  reg ext_pon_r;
  reg cal_en_r;
  reg match_en_r;
  reg period_en_r;
  reg skip_lsb_r;
  reg [2:0] period_sel_r;
  reg [31:0] match_value_r;
  reg match_flag_r;
  reg period_flag_r;

  // Counters
  reg [15:0] sub_sec_r;
  reg [15:0] two_sec_r;
  reg [`RTT_DAY_W-1:0] day_r;

  // Calibration state
  reg [`RTT_CAL_W-1:0] cal_cnt_r;
  reg [`RTT_CAL_W-1:0] cal_res_r;
  reg [2:0] cal_edges_r;
  reg cal_run_r;

  // Bus pipeline
  reg wr_pend_r;
  reg [7:0] wr_addr_r;

  // Slow clock path
  reg slow_prev_r;
  wire slow_raw;
  wire slow_sync;
  wire slow_tick;

  assign slow_clock_source_select = src_sel_r;
  assign internal_slow_osc_power = int_pon_r;
  assign external_slow_osc_power = ext_pon_r;
  assign match_event_flag = match_flag_r;
  assign period_event_flag = period_flag_r;

  // Stalled transfers wait while the clock enable is low
  assign hreadyout = clk_en;
  assign hresp = 1'b0;

  // Selected and powered source
  assign slow_raw = src_sel_r ? (ext_slow_clk & ext_pon_r)
                              : (int_slow_clk & int_pon_r);

  rtt_sync #(
    .W(1)
  ) u_slow_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .async_in(slow_raw),
    .sync_out(slow_sync)
  );

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      slow_prev_r <= 1'b0;
    end else if (clk_en) begin
      slow_prev_r <= slow_sync;
    end
  end

  // A source or power switch while high can fake one tick
  assign slow_tick = slow_sync & ~slow_prev_r;

  // Counter next values
  wire sub_wrap = (sub_sec_r == `RTT_SUB_LAST);
  wire two_wrap = (two_sec_r == `RTT_TWO_SEC_LAST);
  wire [15:0] sub_inc = sub_sec_r + 16'h0001;
  wire [15:0] two_inc = two_wrap ? 16'h0000 : two_sec_r + 16'h0001;
  wire [15:0] two_step = sub_wrap ? two_inc : two_sec_r;
  wire [31:0] time_nxt = {two_step, sub_inc};
  wire day_carry = slow_tick & sub_wrap & two_wrap;

  // Period detection on the stepped time
  wire [31:0] per_mask = (`RTT_PER_BASE << period_sel_r) - 32'h1;
  wire period_hit = slow_tick & period_en_r
                    & ((time_nxt & per_mask) == 32'h0);

  // Match detection on the stepped time
  wire [31:0] cmp_mask = skip_lsb_r ? `RTT_SKIP_MASK : 32'hFFFFFFFF;
  wire match_hit = slow_tick & match_en_r
                   & (((time_nxt ^ match_value_r) & cmp_mask)
                      == 32'h0);

  // Bus address phase
  // Only whole words; hsize is not decoded
  wire addr_ok = hsel & hready & htrans[1];
  wire [7:0] a_ofs = haddr[7:0];

  // Bus data phase write strobes
  wire wr_go = wr_pend_r & clk_en;
  wire wr_cfg = wr_go & (wr_addr_r == `RTT_OFS_OSC_CFG);
  wire wr_cal = wr_go & (wr_addr_r == `RTT_OFS_CAL_CTL);
  wire wr_flg = wr_go & (wr_addr_r == `RTT_OFS_FLAGS);
  wire wr_mod = wr_go & (wr_addr_r == `RTT_OFS_MODE);
  wire wr_mat = wr_go & (wr_addr_r == `RTT_OFS_MATCH);

  wire load_day = wr_mod & hwdata[`RTT_MOD_LOAD_DAY];
  wire load_sec = wr_mod & hwdata[`RTT_MOD_LOAD_SEC];
  wire clr_match = wr_flg & match_en_r & hwdata[`RTT_FLG_MATCH_CLR];
  wire clr_period = wr_flg & period_en_r & hwdata[`RTT_FLG_PERIOD_CLR];

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else if (clk_en) begin
      if (hready) begin
        wr_pend_r <= addr_ok & hwrite;
        wr_addr_r <= a_ofs;
      end
    end
  end

  // Software-written registers
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      src_sel_r <= `RTT_RST_SRC;
      int_pon_r <= `RTT_RST_INT_PON;
      ext_pon_r <= `RTT_RST_EXT_PON;
      cal_en_r <= 1'b0;
      match_en_r <= 1'b0;
      period_en_r <= 1'b0;
      skip_lsb_r <= 1'b0;
      period_sel_r <= `RTT_RST_PSEL;
      match_value_r <= 32'h00000000;
    end else if (clk_en) begin
      if (wr_cfg) begin
        src_sel_r <= hwdata[`RTT_CFG_SRC];
        int_pon_r <= hwdata[`RTT_CFG_INT_PON];
        ext_pon_r <= hwdata[`RTT_CFG_EXT_PON];
      end
      if (wr_cal) begin
        cal_en_r <= hwdata[`RTT_CAL_EN];
      end
      if (wr_mod) begin
        match_en_r <= hwdata[`RTT_MOD_MATCH_EN];
        period_en_r <= hwdata[`RTT_MOD_PERIOD_EN];
        skip_lsb_r <= hwdata[`RTT_MOD_SKIP_LSB];
        period_sel_r <= hwdata[`RTT_MOD_PSEL_HI:`RTT_MOD_PSEL_LO];
      end
      if (wr_mat) begin
        match_value_r <= hwdata;
      end
    end
  end

  // Event flags, a new event wins over a clear
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      match_flag_r <= 1'b0;
      period_flag_r <= 1'b0;
    end else if (clk_en) begin
      if (match_hit) begin
        match_flag_r <= 1'b1;
      end else if (clr_match) begin
        match_flag_r <= 1'b0;
      end
      if (period_hit) begin
        period_flag_r <= 1'b1;
      end else if (clr_period) begin
        period_flag_r <= 1'b0;
      end
    end
  end

  // Time counters; a load overrides a tick in the same cycle
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      sub_sec_r <= 16'h0000;
      two_sec_r <= 16'h0000;
      day_r <= {`RTT_DAY_W{1'b0}};
    end else if (clk_en) begin
      if (load_sec) begin
        two_sec_r <= match_value_r[31:16];
        sub_sec_r <= match_value_r[15:0];
      end else if (slow_tick) begin
        sub_sec_r <= sub_inc;
        two_sec_r <= two_step;
      end
      if (load_day) begin
        day_r <= match_value_r[`RTT_DAY_W-1:0];
      end else if (day_carry & ~load_sec) begin
        day_r <= day_r + {{(`RTT_DAY_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Calibration window end, unit step and saturation
  wire cal_last = cal_run_r & (cal_edges_r == `RTT_CAL_PERIODS - 3'h1);
  wire [`RTT_CAL_W-1:0] cal_one = {{(`RTT_CAL_W-1){1'b0}}, 1'b1};
  wire cal_sat = (cal_cnt_r == `RTT_CAL_MAX);

  // Calibration: main cycles between first and sixth slow edge
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      cal_cnt_r <= {`RTT_CAL_W{1'b0}};
      cal_res_r <= {`RTT_CAL_W{1'b0}};
      cal_edges_r <= 3'h0;
      cal_run_r <= 1'b0;
    end else if (clk_en) begin
      if (!cal_en_r) begin
        cal_run_r <= 1'b0;
        cal_edges_r <= 3'h0;
        cal_cnt_r <= {`RTT_CAL_W{1'b0}};
      end else if (slow_tick) begin
        if (cal_last) begin
          cal_res_r <= cal_cnt_r;
          cal_edges_r <= 3'h0;
        end else if (cal_run_r) begin
          cal_edges_r <= cal_edges_r + 3'h1;
        end
        if (cal_last) begin
          cal_cnt_r <= cal_one;
        end else if (cal_run_r && !cal_sat) begin
          cal_cnt_r <= cal_cnt_r + cal_one;
        end else if (!cal_run_r) begin
          cal_cnt_r <= cal_one;
        end
        cal_run_r <= 1'b1;
      end else if (cal_run_r && !cal_sat) begin
        cal_cnt_r <= cal_cnt_r + cal_one;
      end
    end
  end

  // Read data, registered in the address phase
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    case (a_ofs)
      `RTT_OFS_OSC_CFG: begin
        rd_mux[`RTT_CFG_PIN] = slow_sync;
        rd_mux[`RTT_CFG_SRC] = src_sel_r;
        rd_mux[`RTT_CFG_INT_PON] = int_pon_r;
        rd_mux[`RTT_CFG_EXT_PON] = ext_pon_r;
      end
      `RTT_OFS_CAL_CNT: begin
        rd_mux[`RTT_CAL_W-1:0] = cal_res_r;
      end
      `RTT_OFS_CAL_CTL: begin
        rd_mux[`RTT_CAL_PAUSED] = ~cal_run_r;
        rd_mux[`RTT_CAL_EN] = cal_en_r;
      end
      `RTT_OFS_FLAGS: begin
        rd_mux[`RTT_FLG_MATCH] = match_flag_r;
        rd_mux[`RTT_FLG_PERIOD] = period_flag_r;
        rd_mux[`RTT_FLG_MATCH_CLR] = ~match_en_r;
        rd_mux[`RTT_FLG_PERIOD_CLR] = ~period_en_r;
      end
      `RTT_OFS_MODE: begin
        rd_mux[`RTT_MOD_MATCH_EN] = match_en_r;
        rd_mux[`RTT_MOD_PERIOD_EN] = period_en_r;
        rd_mux[`RTT_MOD_SKIP_LSB] = skip_lsb_r;
        rd_mux[`RTT_MOD_PSEL_HI:`RTT_MOD_PSEL_LO] = period_sel_r;
      end
      `RTT_OFS_MATCH: begin
        rd_mux = match_value_r;
      end
      `RTT_OFS_SUB_SEC: begin
        rd_mux[15:0] = sub_sec_r;
      end
      `RTT_OFS_TWO_SEC: begin
        rd_mux[15:0] = two_sec_r;
      end
      `RTT_OFS_DAY: begin
        rd_mux[`RTT_DAY_W-1:0] = day_r;
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      hrdata <= 32'h00000000;
    end else if (clk_en) begin
      if (addr_ok & ~hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

endmodule
